/* File: hdl/sri_defs.vh */
`ifndef SRI_DEFS_VH
`define SRI_DEFS_VH

// Frame layout
`define SRI_FRAME_BITS   5'h10
`define SRI_HDR_BITS     5'h04
`define SRI_CNT_MAX      5'h1f
`define SRI_ADDR_HI      15
`define SRI_ADDR_LO      14
`define SRI_RRS_BIT      13
`define SRI_RO_BIT       12
`define SRI_DATA_HI      11
`define SRI_HDR_OUT      4'h0

// Register addresses
`define SRI_ADDR_MODE    2'h0
`define SRI_ADDR_IRQ     2'h1
`define SRI_ADDR_CFG     2'h2
`define SRI_ADDR_PHY     2'h3

// Mode-control fields
`define SRI_NWP_HI       11
`define SRI_NWP_LO       6
`define SRI_OM_HI        5
`define SRI_OM_LO        3

// Operating-mode codes written by software
`define SRI_OM_NORMAL    3'h1
`define SRI_OM_STANDBY   3'h2
`define SRI_OM_INIT_FL   3'h3
`define SRI_OM_SLEEP     3'h4
`define SRI_OM_INIT_NM   3'h5
`define SRI_OM_LEAVE_FL  3'h6
`define SRI_OM_FLASH     3'h7

// Legal watchdog period codes
`define SRI_WD_C0        6'h09
`define SRI_WD_C1        6'h0c
`define SRI_WD_C2        6'h12
`define SRI_WD_C3        6'h14
`define SRI_WD_C4        6'h1b
`define SRI_WD_C5        6'h24
`define SRI_WD_C6        6'h2d
`define SRI_WD_C7        6'h33
`define SRI_WD_C8        6'h35
`define SRI_WD_C9        6'h36

// One-hot operating modes
`define SRI_M_NONE       6'h00
`define SRI_M_STARTUP    6'h01
`define SRI_M_RESTART    6'h02
`define SRI_M_NORMAL     6'h04
`define SRI_M_STANDBY    6'h08
`define SRI_M_FLASH      6'h10
`define SRI_M_SLEEP      6'h20

// Interrupt flag positions
`define SRI_IRQ_SPI      0
`define SRI_IRQ_EVT_LO   1
`define SRI_IRQ_OT       3
`define SRI_IRQ_W        4

// Reset source codes
`define SRI_RS_NONE      2'h0
`define SRI_RS_SPI       2'h1
`define SRI_RS_MODE      2'h2
`define SRI_RS_IRQ       2'h3

// Reset values
`define SRI_REG_RST      12'h000
`define SRI_FRM_RST      16'h0000

// Timing
`define SRI_CLK_PERIOD_NS 4
`define SRI_T_IRQ_REL_NS  2000
`define SRI_T_IRQ_TMO_NS  256000
`define SRI_T_RST_NS      20000

`endif

/* File: hdl/sri_sync.v */
`timescale 1ns/1ps
`default_nettype none

module sri_sync #(
  parameter           W       = 1,
  parameter [W-1:0]   RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // Asynchronous in, synchronous out
  input  wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;

endmodule

`default_nettype wire

/* File: hdl/sri_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "sri_defs.vh"

module sri_top #(
  parameter CNT_W       = 17,
  parameter IRQ_REL_CYC = (`SRI_T_IRQ_REL_NS + `SRI_CLK_PERIOD_NS - 1) / `SRI_CLK_PERIOD_NS,
  parameter IRQ_TMO_CYC = `SRI_T_IRQ_TMO_NS / `SRI_CLK_PERIOD_NS,
  parameter RST_CYC     = (`SRI_T_RST_NS + `SRI_CLK_PERIOD_NS - 1) / `SRI_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Serial port
  input  wire        port_select_n,
  input  wire        sclk_in,
  input  wire        sdi_in,
  output reg         sdo_out,
  output reg         sdo_oe,
  // Interrupt pin, open drain
  input  wire        irq_out_n_in,
  output reg         irq_out_n_o,
  output reg         irq_out_n_oe,
  // System reset pin, open drain
  output reg         sys_reset_out_n_o,
  output reg         sys_reset_out_n_oe,
  // Event sources
  input  wire        line_short_in,
  input  wire        tx_clamp_in,
  input  wire        overtemp_in,
  // Control outputs
  output reg  [5:0]  op_mode,
  output reg  [11:0] mode_ctrl_out,
  output reg  [11:0] sys_cfg_out,
  output reg  [11:0] line_phy_out
);

  localparam [CNT_W-1:0] REL_C  = IRQ_REL_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] TMO_C  = IRQ_TMO_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] RST_C  = RST_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] ONE_C  = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0] ZERO_C = {CNT_W{1'b0}};

  // Pin synchronisers; select resets high so no false frame start
  wire [6:0] sync_q;
  sri_sync #(
    .W       (7),
    .RST_VAL (7'h01)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d_in    ({overtemp_in, tx_clamp_in, line_short_in, irq_out_n_in,
               sdi_in, sclk_in, port_select_n}),
    .q_out   (sync_q)
  );

  wire       cs_n_s  = sync_q[0];
  wire       sclk_s  = sync_q[1];
  wire       sdi_s   = sync_q[2];
  wire       irq_pin = sync_q[3];
  wire [2:0] src_s   = sync_q[6:4];

  reg        cs_prev_r;
  reg        sclk_prev_r;
  reg  [4:0] cnt_r;
  reg [15:0] rx_r;
  reg [15:0] tx_r;
  reg [11:0] mode_r;
  reg [11:0] irq_en_r;
  reg [11:0] special_r;
  reg [11:0] gp0_r;
  reg [11:0] gp1_r;
  reg [`SRI_IRQ_W-1:0] flags_r;
  reg  [2:0] once_r;
  reg  [2:0] src_prev_r;
  reg  [1:0] rst_src_r;
  reg [CNT_W-1:0] rel_r;
  reg [CNT_W-1:0] tmo_r;
  reg [CNT_W-1:0] rstc_r;

  wire cs_fall   = cs_prev_r & ~cs_n_s;
  wire cs_rise   = ~cs_prev_r & cs_n_s;
  wire sclk_rise = ~cs_n_s & sclk_s & ~sclk_prev_r;
  wire sclk_fall = ~cs_n_s & ~sclk_s & sclk_prev_r;
  wire rst_act   = (rstc_r != ZERO_C);

  wire is_nrm  = (op_mode == `SRI_M_NORMAL);
  wire is_sby  = (op_mode == `SRI_M_STANDBY);
  wire is_fls  = (op_mode == `SRI_M_FLASH);
  wire is_boot = (op_mode == `SRI_M_STARTUP) | (op_mode == `SRI_M_RESTART);

  wire [1:0]  f_addr = rx_r[`SRI_ADDR_HI:`SRI_ADDR_LO];
  wire        f_rrs  = rx_r[`SRI_RRS_BIT];
  wire        f_ro   = rx_r[`SRI_RO_BIT];
  wire [11:0] f_data = rx_r[`SRI_DATA_HI:0];
  wire [2:0]  f_om   = f_data[`SRI_OM_HI:`SRI_OM_LO];
  wire [5:0]  f_nwp  = f_data[`SRI_NWP_HI:`SRI_NWP_LO];

  // header seen at the fourth falling edge, newest bit from the line
  wire [3:0]  hdr_now = {rx_r[2:0], sdi_s};

  function wd_ok;
    input [5:0] c;
    begin
      case (c)
        `SRI_WD_C0, `SRI_WD_C1, `SRI_WD_C2, `SRI_WD_C3, `SRI_WD_C4,
        `SRI_WD_C5, `SRI_WD_C6, `SRI_WD_C7, `SRI_WD_C8, `SRI_WD_C9: wd_ok = 1'b1;
        default: wd_ok = 1'b0;
      endcase
    end
  endfunction

  // allowed transitions; none marks forbidden or undefined
  function [5:0] next_mode;
    input [5:0] cur;
    input [2:0] om;
    begin
      next_mode = `SRI_M_NONE;
      case (cur)
        `SRI_M_STARTUP, `SRI_M_RESTART: begin
          if (om == `SRI_OM_INIT_NM)
            next_mode = `SRI_M_NORMAL;
          else if (om == `SRI_OM_INIT_FL)
            next_mode = `SRI_M_FLASH;
        end
        `SRI_M_NORMAL, `SRI_M_STANDBY: begin
          if (om == `SRI_OM_NORMAL)
            next_mode = `SRI_M_NORMAL;
          else if (om == `SRI_OM_STANDBY)
            next_mode = `SRI_M_STANDBY;
          else if (om == `SRI_OM_SLEEP)
            next_mode = `SRI_M_SLEEP;
        end
        `SRI_M_FLASH: begin
          if (om == `SRI_OM_FLASH)
            next_mode = `SRI_M_FLASH;
          else if (om == `SRI_OM_LEAVE_FL)
            next_mode = `SRI_M_NORMAL;
        end
        default: next_mode = `SRI_M_NONE;
      endcase
    end
  endfunction

  // Status and diagnosis views of block state
  wire [11:0] sys_status = {2'b00, rst_src_r, irq_pin, src_s[2], op_mode};
  wire [11:0] sys_diag   = {9'h000, src_s};

  reg [11:0] rb;
  always @* begin
    rb = `SRI_REG_RST;
    case (hdr_now[3:2])
      `SRI_ADDR_MODE: rb = hdr_now[1] ? sys_diag : sys_status;
      // flags in run modes, setup feedback in boot modes
      `SRI_ADDR_IRQ: begin
        if (!hdr_now[1])
          rb = irq_en_r;
        else if (is_boot)
          rb = special_r;
        else
          rb = {{(12-`SRI_IRQ_W){1'b0}}, flags_r};
      end
      `SRI_ADDR_CFG: rb = hdr_now[1] ? gp0_r : sys_cfg_out;
      // line control or scratch one feedback
      `SRI_ADDR_PHY: rb = hdr_now[1] ? gp1_r : line_phy_out;
      default: rb = `SRI_REG_RST;
    endcase
  end

  // frame is valid only with exactly sixteen clocks
  wire frame_ok  = cs_rise & (cnt_r == `SRI_FRAME_BITS);
  wire frame_bad = cs_rise & (cnt_r != `SRI_FRAME_BITS);
  // writes only when read-only flag is clear
  wire do_wr     = frame_ok & ~f_ro & ~rst_act;
  wire [5:0] nm  = next_mode(op_mode, f_om);
  // illegal mode write is discarded and escalates
  wire mode_bad  = do_wr & (f_addr == `SRI_ADDR_MODE) &
                   (~wd_ok(f_nwp) | (nm == `SRI_M_NONE));
  // mode applied only with a watchdog service
  wire wd_serve  = do_wr & (f_addr == `SRI_ADDR_MODE) & ~mode_bad;
  // read of the flag register clears it
  wire clr_rd    = frame_ok & (f_addr == `SRI_ADDR_IRQ) & f_rrs & ~is_boot & ~rst_act;
  // boot modes escalate a count fault
  wire spi_rst   = frame_bad & is_boot;
  wire tmo_hit   = (tmo_r == TMO_C - ONE_C) & (flags_r != {`SRI_IRQ_W{1'b0}});
  wire rst_evt   = ~rst_act & (spi_rst | mode_bad | tmo_hit);

  wire [2:0] evt;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_evt
      if (gi == 2) begin : g_ot
        assign evt[gi] = src_s[gi] & ~src_prev_r[gi];
      end else begin : g_chg
        assign evt[gi] = src_s[gi] ^ src_prev_r[gi];
      end
    end
  endgenerate

  // in normal mode a source fires once until the next service
  wire [2:0] evt_set = evt & irq_en_r[`SRI_IRQ_OT:`SRI_IRQ_EVT_LO] &
                       ~(once_r & {3{is_nrm}});
  // count fault flags only outside boot modes
  wire spi_set = frame_bad & ~is_boot & irq_en_r[`SRI_IRQ_SPI];
  wire [`SRI_IRQ_W-1:0] set_vec = {evt_set, spi_set};

  reg [`SRI_IRQ_W-1:0] flags_nxt;
  reg [CNT_W-1:0]      rel_nxt;
  always @* begin
    flags_nxt = flags_r;
    if (clr_rd)
      flags_nxt = {`SRI_IRQ_W{1'b0}};
    // A new event in the clearing cycle survives
    flags_nxt = flags_nxt | set_vec;
    // held clear while reset output is low
    if (rst_act | rst_evt)
      flags_nxt = {`SRI_IRQ_W{1'b0}};
    rel_nxt = rel_r;
    if (clr_rd)
      rel_nxt = REL_C;
    else if (rel_r != ZERO_C)
      rel_nxt = rel_r - ONE_C;
  end

  // Serial engine
  always @(posedge clk) begin
    if (sys_rst) begin
      cs_prev_r   <= 1'b1;
      sclk_prev_r <= 1'b0;
      cnt_r       <= 5'h00;
      rx_r        <= `SRI_FRM_RST;
      tx_r        <= `SRI_FRM_RST;
      sdo_out     <= 1'b0;
      sdo_oe      <= 1'b0;
    end else begin
      cs_prev_r   <= cs_n_s;
      sclk_prev_r <= sclk_s;
      // output floats while select is high
      sdo_oe      <= ~cs_n_s;
      if (cs_fall) begin
        cnt_r   <= 5'h00;
        tx_r    <= {`SRI_HDR_OUT, `SRI_REG_RST};
        sdo_out <= 1'b0;
      end else if (cs_n_s) begin
        sdo_out <= 1'b0;
      end else begin
        if (sclk_fall) begin
          rx_r <= {rx_r[14:0], sdi_s};
          if (cnt_r != `SRI_CNT_MAX)
            cnt_r <= cnt_r + 5'h01;
        end
        // load readback once the header is in
        if (sclk_fall & (cnt_r == `SRI_HDR_BITS - 5'h01))
          tx_r <= {rb, `SRI_HDR_OUT};
        // shift out on rising edge, top bit first
        else if (sclk_rise) begin
          sdo_out <= tx_r[15];
          tx_r    <= {tx_r[14:0], 1'b0};
        end
      end
    end
  end

  // Register file and mode
  always @(posedge clk) begin
    if (sys_rst) begin
      op_mode       <= `SRI_M_STARTUP;
      mode_r        <= `SRI_REG_RST;
      irq_en_r      <= `SRI_REG_RST;
      special_r     <= `SRI_REG_RST;
      gp0_r         <= `SRI_REG_RST;
      gp1_r         <= `SRI_REG_RST;
      sys_cfg_out   <= `SRI_REG_RST;
      line_phy_out  <= `SRI_REG_RST;
      mode_ctrl_out <= `SRI_REG_RST;
      rst_src_r     <= `SRI_RS_NONE;
    end else if (rst_evt | rst_act) begin
      // Reset restarts boot handshake; control bits fall back
      op_mode       <= `SRI_M_STARTUP;
      mode_r        <= `SRI_REG_RST;
      mode_ctrl_out <= `SRI_REG_RST;
      irq_en_r      <= `SRI_REG_RST;
      sys_cfg_out   <= `SRI_REG_RST;
      line_phy_out  <= `SRI_REG_RST;
      if (spi_rst)
        rst_src_r <= `SRI_RS_SPI;
      else if (mode_bad)
        rst_src_r <= `SRI_RS_MODE;
      else if (tmo_hit)
        rst_src_r <= `SRI_RS_IRQ;
    end else if (do_wr) begin
      case (f_addr)
        `SRI_ADDR_MODE: begin
          if (wd_serve) begin
            mode_r        <= f_data;
            mode_ctrl_out <= f_data;
            op_mode       <= nm;
          end
        end
        // enables in run modes, special setup in boot modes
        `SRI_ADDR_IRQ: begin
          if (is_boot)
            special_r <= f_data;
          else if (is_nrm | is_sby | is_fls)
            irq_en_r <= f_data;
        end
        `SRI_ADDR_CFG: begin
          if (is_nrm | is_sby)
            sys_cfg_out <= f_data;
          else
            gp0_r <= f_data;
        end
        `SRI_ADDR_PHY: begin
          if (is_nrm | is_sby)
            line_phy_out <= f_data;
          else
            gp1_r <= f_data;
        end
        default: gp1_r <= gp1_r;
      endcase
    end
  end

  // Interrupt flags, release window, timeout and reset pulse
  always @(posedge clk) begin
    if (sys_rst) begin
      flags_r            <= {`SRI_IRQ_W{1'b0}};
      once_r             <= 3'h0;
      src_prev_r         <= 3'h0;
      rel_r              <= ZERO_C;
      tmo_r              <= ZERO_C;
      rstc_r             <= ZERO_C;
      irq_out_n_o        <= 1'b0;
      irq_out_n_oe       <= 1'b0;
      sys_reset_out_n_o  <= 1'b0;
      sys_reset_out_n_oe <= 1'b0;
    end else begin
      src_prev_r <= src_s;
      flags_r    <= flags_nxt;
      rel_r      <= rel_nxt;
      // period boundary is each watchdog service
      if (wd_serve | rst_act)
        once_r <= 3'h0;
      else if (is_nrm)
        once_r <= once_r | evt_set;
      // count while flags stay pending and unread
      if (clr_rd | rst_act | (flags_r == {`SRI_IRQ_W{1'b0}}))
        tmo_r <= ZERO_C;
      else if (tmo_r != TMO_C)
        tmo_r <= tmo_r + ONE_C;
      // reset pulse held for its full length
      if (rst_evt)
        rstc_r <= RST_C;
      else if (rst_act)
        rstc_r <= rstc_r - ONE_C;
      sys_reset_out_n_oe <= rst_evt | (rstc_r > ONE_C);
      // pull low while any flag is set
      // but stay released during the window after readout
      irq_out_n_oe <= (rel_nxt == ZERO_C) & (flags_nxt != {`SRI_IRQ_W{1'b0}});
    end
  end

endmodule

`default_nettype wire

/* File: tb/sri_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sri_host_model (
  // Clock
  input  wire logic clk,
  // Serial pins
  output var  logic sel_n,
  output var  logic sclk,
  output var  logic sdi,
  input  wire logic sdo
);
  initial begin
    sel_n = 1'b1;
    sclk  = 1'b0;
    sdi   = 1'b0;
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic xfer(input int n, input logic [16:0] w, output logic [15:0] r);
    int i;
    r = 16'h0000;
    step(1);
    sel_n = 1'b0;
    for (i = 0; i < n; i++) begin
      step(4);
      sclk = 1'b1;
      sdi  = w[16-i];
      step(4);
      r    = {r[14:0], sdo};
      sclk = 1'b0;
    end
    step(4);
    sel_n = 1'b1;
    // Flip the idle data so a stale bit never looks valid
    sdi = ~sdi;
    step(12);
  endtask
endmodule
`default_nettype wire

/* File: tb/sri_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sri_defs.vh"
module sri_top_chk #(
  parameter IRQ_REL_CYC = 500,
  parameter IRQ_TMO_CYC = 64000,
  parameter RST_CYC     = 5000
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Observed ports
  input wire logic        port_select_n,
  input wire logic        sclk_in,
  input wire logic        sdo_out,
  input wire logic        sdo_oe,
  input wire logic        irq_out_n_o,
  input wire logic        irq_out_n_oe,
  input wire logic        sys_reset_out_n_oe,
  input wire logic [5:0]  op_mode,
  input wire logic [11:0] sys_cfg_out,
  input wire logic [11:0] line_phy_out
);
  logic [8:0]  sclk_h;
  logic [15:0] rst_cnt;
  logic [15:0] low_cnt;
  logic [15:0] hi_cnt;
  // Low count saturates so a long idle never wraps into a false short window
  always @(posedge clk) begin
    if (sys_rst) begin
      sclk_h  <= 9'h000;
      rst_cnt <= 16'h0000;
      low_cnt <= 16'hffff;
      hi_cnt  <= 16'h0000;
    end else begin
      sclk_h  <= {sclk_h[7:0], sclk_in};
      rst_cnt <= sys_reset_out_n_oe ? rst_cnt + 16'h0001 : 16'h0000;
      // A drop caused by a reset pulse is not a readout, so it opens no window
      low_cnt <= irq_out_n_oe ? 16'h0000 :
                 ((sys_reset_out_n_oe | &low_cnt) ? 16'hffff : low_cnt + 16'h0001);
      hi_cnt  <= irq_out_n_oe ? hi_cnt + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_sel_idle;
    port_select_n [*5];
  endsequence
  sequence s_rst_held;
    sys_reset_out_n_oe [*3];
  endsequence
  AST_SDO_FLOAT: assert property (s_sel_idle |-> !sdo_oe)
    else $error("data output enabled while deselected");
  AST_SDO_IDLE: assert property (!sdo_oe |-> !sdo_out)
    else $error("data output not parked low");
  AST_SDO_ON_RISE: assert property ($changed(sdo_out) && sdo_oe |-> |(sclk_h[7:0] & ~sclk_h[8:1]))
    else $error("data output moved without a clock rise");
  AST_RST_LEN: assert property ($fell(sys_reset_out_n_oe) |-> rst_cnt == RST_CYC)
    else $error("reset pulse length wrong");
  AST_RST_MODE: assert property ($rose(sys_reset_out_n_oe) |-> ##[0:2] op_mode == `SRI_M_STARTUP)
    else $error("reset did not return to start-up");
  AST_RST_CLEAR: assert property (s_rst_held |-> !irq_out_n_oe && sys_cfg_out == 12'h000 && line_phy_out == 12'h000)
    else $error("state not cleared during reset");
  AST_IRQ_RELEASE: assert property ($rose(irq_out_n_oe) |-> low_cnt >= IRQ_REL_CYC - 1)
    else $error("interrupt released too briefly");
  AST_IRQ_TMO: assert property (hi_cnt <= IRQ_TMO_CYC + 4)
    else $error("pending interrupt outlived its timeout");
  AST_IRQ_DRIVE: assert property (irq_out_n_oe |-> irq_out_n_o == 1'b0)
    else $error("interrupt pin not pulled low");
  AST_MODE_AT_END: assert property ($changed(op_mode) |-> ##[0:1] (port_select_n || sys_reset_out_n_oe))
    else $error("mode changed inside a frame");
endmodule
bind sri_top sri_top_chk #(
  .IRQ_REL_CYC(IRQ_REL_CYC), .IRQ_TMO_CYC(IRQ_TMO_CYC), .RST_CYC(RST_CYC)
) u_chk (
  .clk(clk), .sys_rst(sys_rst), .port_select_n(port_select_n), .sclk_in(sclk_in),
  .sdo_out(sdo_out), .sdo_oe(sdo_oe), .irq_out_n_o(irq_out_n_o), .irq_out_n_oe(irq_out_n_oe),
  .sys_reset_out_n_oe(sys_reset_out_n_oe), .op_mode(op_mode), .sys_cfg_out(sys_cfg_out),
  .line_phy_out(line_phy_out)
);
`default_nettype wire

/* File: tb/spi_register_access_irq_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sri_defs.vh"
module spi_register_access_irq_test;
  localparam int REL = 20;
  localparam int TMO = 2000;
  localparam int RCY = 10;
  logic        clk;
  logic        sys_rst;
  logic        sel_n, sclk, sdi;
  logic        sdo_out, sdo_oe, irq_o, irq_oe, rst_o, rst_oe;
  logic        line_short, tx_clamp, overtemp;
  logic [5:0]  op_mode;
  logic [11:0] mode_ctrl, sys_cfg, line_phy;
  logic [15:0] r;
  wire         sdo_w;
  wire         irq_w;
  int          failures, total_checks, i;
  assign sdo_w = sdo_oe ? sdo_out : 1'bz;
  // Open-drain pin with pull-up
  assign irq_w = irq_oe ? irq_o : 1'b1;
  sri_top #(.IRQ_REL_CYC(REL), .IRQ_TMO_CYC(TMO), .RST_CYC(RCY)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .port_select_n(sel_n), .sclk_in(sclk), .sdi_in(sdi),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .irq_out_n_in(irq_w), .irq_out_n_o(irq_o),
    .irq_out_n_oe(irq_oe), .sys_reset_out_n_o(rst_o), .sys_reset_out_n_oe(rst_oe),
    .line_short_in(line_short), .tx_clamp_in(tx_clamp), .overtemp_in(overtemp),
    .op_mode(op_mode), .mode_ctrl_out(mode_ctrl), .sys_cfg_out(sys_cfg), .line_phy_out(line_phy)
  );
  sri_host_model u_host (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_w));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wait_oe(input int which, input logic v, input int lim);
    int n;
    n = 0;
    while ((which ? rst_oe : irq_oe) !== v && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) begin
      failures++;
      final_report();
    end
  endtask
  function automatic logic [16:0] fr(input logic [1:0] a, input logic s, input logic ro,
                                     input logic [11:0] d);
    return {a, s, ro, d, 1'b0};
  endfunction
  task automatic xf(input int n, input logic [16:0] w);
    u_host.xfer(n, w, r);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    final_report();
  end
  initial begin
    sys_rst = 1'b1;
    line_short = 1'b0;
    tx_clamp = 1'b0;
    overtemp = 1'b0;
    failures = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    step(4);
    check(sdo_oe, 1'b0);
    check(op_mode, `SRI_M_STARTUP);
    // Start-up writes land in special setup and scratch
    for (i = 1; i < 4; i++) begin
      xf(16, fr(i[1:0], 1'b0, 1'b0, 12'h3c0 + i[11:0]));
      xf(16, fr(i[1:0], 1'b1, 1'b1, 12'h000));
      check(r, 16'h03c0 + i[15:0]);
    end
    check(sys_cfg, 12'h000);
    check(line_phy, 12'h000);
    xf(16, fr(`SRI_ADDR_MODE, 1'b0, 1'b0, 12'h268));
    check(r[7:0], 8'h81);
    check(op_mode, `SRI_M_NORMAL);
    check(mode_ctrl, 12'h268);
    xf(16, fr(`SRI_ADDR_MODE, 1'b0, 1'b1, 12'hfff));
    check({rst_oe, mode_ctrl}, 16'h0268);
    check(op_mode, `SRI_M_NORMAL);
    xf(16, fr(`SRI_ADDR_IRQ, 1'b0, 1'b0, 12'h00f));
    xf(16, fr(`SRI_ADDR_IRQ, 1'b0, 1'b1, 12'h000));
    check(r, 16'h000f);
    for (i = 2; i < 4; i++) begin
      xf(16, fr(i[1:0], 1'b0, 1'b0, 12'ha50 + i[11:0]));
      xf(16, fr(i[1:0], 1'b0, 1'b1, 12'h000));
      check(r, 16'h0a50 + i[15:0]);
    end
    check(sys_cfg, 12'ha52);
    check(line_phy, 12'ha53);
    // Short and long frames are dropped
    xf(15, fr(`SRI_ADDR_CFG, 1'b0, 1'b0, 12'h000));
    wait_oe(0, 1'b1, 20);
    check(irq_w, 1'b0);
    xf(17, fr(`SRI_ADDR_CFG, 1'b0, 1'b0, 12'h000));
    check(sys_cfg, 12'ha52);
    xf(16, fr(`SRI_ADDR_IRQ, 1'b1, 1'b1, 12'h000));
    check(r, 16'h0001);
    // New event lands inside the release window
    line_short = 1'b1;
    step(REL / 4);
    check(irq_oe, 1'b0);
    wait_oe(0, 1'b1, REL + 20);
    check(irq_oe, 1'b1);
    xf(16, fr(`SRI_ADDR_IRQ, 1'b1, 1'b1, 12'h000));
    check(r, 16'h0002);
    line_short = 1'b0;
    step(REL + 20);
    check(irq_oe, 1'b0);
    xf(16, fr(`SRI_ADDR_MODE, 1'b0, 1'b0, 12'h248));
    check(op_mode, `SRI_M_NORMAL);
    overtemp = 1'b1;
    tx_clamp = 1'b1;
    wait_oe(0, 1'b1, 20);
    check(irq_oe, 1'b1);
    xf(16, fr(`SRI_ADDR_MODE, 1'b1, 1'b1, 12'h000));
    check(r[2:0], 3'h6);
    // Leave the flag unread
    wait_oe(1, 1'b1, TMO + 200);
    step(3);
    check(rst_o, 1'b0);
    check({irq_oe, op_mode}, {1'b0, `SRI_M_STARTUP});
    wait_oe(1, 1'b0, RCY + 10);
    check(sys_cfg, 12'h000);
    overtemp = 1'b0;
    tx_clamp = 1'b0;
    step(8);
    xf(15, fr(`SRI_ADDR_MODE, 1'b0, 1'b1, 12'h000));
    step(RCY + 10);
    xf(16, fr(`SRI_ADDR_MODE, 1'b0, 1'b1, 12'h000));
    check(r, 16'h0181);
    xf(16, fr(`SRI_ADDR_MODE, 1'b0, 1'b0, 12'h268));
    check(op_mode, `SRI_M_NORMAL);
    xf(16, fr(`SRI_ADDR_MODE, 1'b0, 1'b0, 12'h278));
    step(RCY + 10);
    xf(16, fr(`SRI_ADDR_MODE, 1'b0, 1'b1, 12'h000));
    check(r, 16'h0281);
    xf(16, fr(`SRI_ADDR_MODE, 1'b0, 1'b0, 12'h028));
    step(RCY + 10);
    xf(16, fr(`SRI_ADDR_MODE, 1'b0, 1'b1, 12'h000));
    check(r, 16'h0281);
    check(mode_ctrl, 12'h000);
    final_report();
  end
endmodule
`default_nettype wire
